// ### src/timer_capture_compare_unit.sv
// timer capture and compare unit with an ahb-lite register slave
// Function
// - capture registers one to three keep contents through reset
// - compare registers reset to all ones
// - shared pair is capture four or compare five
// - shared pair ignores writes while capturing
// - shared pair resets to all ones
// - mode/level pair disconnects, toggles, clears, sets pin
// - edge field selects off, rising, falling, any
// - compare flag with enable requests interrupt
// - capture flag with enable requests interrupt
// - select one: shared enable serves capture four
// - select zero: shared enable serves compare five
// - flags clear only where one is written
// - compare flag sets on counter match
// - shared flag follows the selected function
// - capture flag sets on selected edge
// - select zero compare five, one capture four
// - enable bits map one-to-one onto flags
// - wrap flag sets when counter wraps to zero
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module timer_capture_compare_unit (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic        hresp,
  output var  logic [31:0] hrdata,
  // port a timer pins (bits 7..3 compare, 3..0 capture)
  input  wire logic [3:0]  portAIn,
  output var  logic [7:3]  portAOut,
  output var  logic [7:3]  portAOe_n,
  // interrupt request
  output var  logic        timerIrq
);

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic resetSyncA;
  logic rstN;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      resetSyncA <= 1'b0;
      rstN       <= 1'b0;
    end else begin
      resetSyncA <= 1'b1;
      rstN       <= resetSyncA;
    end
  end

  // ---------------------------------------------------------------
  // decoding helpers
  // ---------------------------------------------------------------
  function automatic logic captureHit(input logic [1:0] edgeSel,
                                      input logic prev, input logic cur);
    unique case (edgeSel)
      tcc_pkg::EDGE_OFF:  captureHit = 1'b0;
      tcc_pkg::EDGE_RISE: captureHit = !prev && cur;
      tcc_pkg::EDGE_FALL: captureHit = prev && !cur;
      default:            captureHit = prev != cur;
    endcase
  endfunction : captureHit

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  tcc_pkg::busPhase_t dataPh;
  tcc_pkg::busPhase_t next_dataPh;
  logic [31:0] next_hrdata;
  logic        next_hreadyout;
  logic [3:0]  pinSyncA;
  logic [3:0]  pinSync;
  logic [3:0]  pinPrev;
  logic [15:0] count;
  logic [15:0] next_count;
  logic [3:0]  preCnt;
  logic [3:0]  next_preCnt;
  logic        cntNew;
  logic        tick;
  logic [15:0] cmpVal [4];
  logic [15:0] next_cmpVal [4];
  logic [15:0] sharedVal;
  logic [15:0] next_sharedVal;
  logic [15:0] capVal [3];
  logic [7:0]  pinMask, next_pinMask;
  logic [7:0]  pinData, next_pinData;
  logic [7:0]  actCtl, next_actCtl;
  logic [7:0]  edgeCtl, next_edgeCtl;
  logic [7:0]  ien, next_ien;
  logic [7:0]  flags, next_flags;
  logic [7:0]  cntCtl, next_cntCtl;
  logic        wrapFlag, next_wrapFlag;
  logic        sharedSel, next_sharedSel;
  logic [7:3]  next_portAOut;
  logic [7:3]  next_portAOe_n;
  logic        next_timerIrq;
  logic [4:0]  cmpHit;
  logic [3:0]  capHit;
  logic [7:0]  setFlags;
  logic        wrEn;
  logic [31:0] rdMux;

  // ---------------------------------------------------------------
  // event detection
  // ---------------------------------------------------------------
  assign wrEn = dataPh.valid && dataPh.write;

  generate
    for (genvar i = 0; i < 4; i++) begin : g_cmp
      assign cmpHit[i] = cntNew && (count == cmpVal[i]);
    end
  endgenerate
  // compare five only when select is zero
  assign cmpHit[4] = cntNew && !sharedSel && (count == sharedVal);

  generate
    for (genvar i = 0; i < 3; i++) begin : g_cap
      assign capHit[i] = captureHit(edgeCtl[5-2*i -: 2], pinPrev[i],
                                    pinSync[i]);
    end
  endgenerate
  // capture four only when select is one
  assign capHit[3] = sharedSel &&
                     captureHit(edgeCtl[7:6], pinPrev[3], pinSync[3]);

  // shared flag source follows the select bit
  assign setFlags = {cmpHit[0], cmpHit[1], cmpHit[2], cmpHit[3],
                     sharedSel ? capHit[3] : cmpHit[4],
                     capHit[0], capHit[1], capHit[2]};

  // ---------------------------------------------------------------
  // read multiplexer
  // ---------------------------------------------------------------
  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (dataPh.idx)
      tcc_pkg::IDX_COMPARE_ONE_PIN_MASK: rdMux[7:0] = pinMask;
      tcc_pkg::IDX_COMPARE_ONE_PIN_DATA: rdMux[7:0] = pinData;
      tcc_pkg::IDX_FREE_RUNNING_COUNT:   rdMux[15:0] = count;
      tcc_pkg::IDX_CAPTURE_VALUE_ONE:    rdMux[15:0] = capVal[0];
      tcc_pkg::IDX_CAPTURE_VALUE_TWO:    rdMux[15:0] = capVal[1];
      tcc_pkg::IDX_CAPTURE_VALUE_THREE:  rdMux[15:0] = capVal[2];
      tcc_pkg::IDX_COMPARE_VALUE_ONE:    rdMux[15:0] = cmpVal[0];
      tcc_pkg::IDX_COMPARE_VALUE_TWO:    rdMux[15:0] = cmpVal[1];
      tcc_pkg::IDX_COMPARE_VALUE_THREE:  rdMux[15:0] = cmpVal[2];
      tcc_pkg::IDX_COMPARE_VALUE_FOUR:   rdMux[15:0] = cmpVal[3];
      tcc_pkg::IDX_SHARED_VALUE:         rdMux[15:0] = sharedVal;
      tcc_pkg::IDX_PIN_ACTION_CONTROL:   rdMux[7:0] = actCtl;
      tcc_pkg::IDX_CAPTURE_EDGE_CONTROL: rdMux[7:0] = edgeCtl;
      tcc_pkg::IDX_INTERRUPT_ENABLES:    rdMux[7:0] = ien;
      tcc_pkg::IDX_EVENT_FLAGS:          rdMux[7:0] = flags;
      tcc_pkg::IDX_COUNTER_CONTROL:      rdMux[7:0] = cntCtl;
      tcc_pkg::IDX_COUNTER_FLAGS:
        rdMux[tcc_pkg::BIT_WRAP_FLAG] = wrapFlag;
      tcc_pkg::IDX_PULSE_CONTROL:
        rdMux[tcc_pkg::BIT_SHARED_SELECT] = sharedSel;
      default:                           rdMux = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    // bus: reads take one wait state so a preceding write is visible
    next_dataPh    = dataPh;
    next_hrdata    = hrdata;
    next_hreadyout = 1'b1;
    if (!hreadyout) begin
      next_hrdata = rdMux;
    end else if (hready) begin
      next_dataPh.valid = hsel && htrans[1];
      next_dataPh.write = hwrite;
      next_dataPh.idx   = haddr[9:2];
      next_hreadyout    = !(hsel && htrans[1] && !hwrite);
    end
    if (!hreadyout || (dataPh.valid && !dataPh.write && hreadyout)) begin
      next_dataPh.valid = next_dataPh.valid && hreadyout;
    end

    // prescaled count, no software write path
    next_preCnt = preCnt + 4'h1;
    unique case (cntCtl[1:0])
      2'h0:    tick = 1'b1;
      2'h1:    tick = preCnt >= 4'h3;
      2'h2:    tick = preCnt >= 4'h7;
      default: tick = preCnt >= 4'hf;
    endcase
    if (tick) begin
      next_preCnt = 4'h0;
    end
    next_count = tick ? count + 16'h0001 : count;

    next_cmpVal    = cmpVal;
    next_sharedVal = sharedVal;
    next_pinMask   = pinMask;
    next_pinData   = pinData;
    next_actCtl    = actCtl;
    next_edgeCtl   = edgeCtl;
    next_ien       = ien;
    next_cntCtl    = cntCtl;
    next_sharedSel = sharedSel;
    next_flags     = flags;
    next_wrapFlag  = wrapFlag;
    if (wrEn) begin
      unique case (dataPh.idx)
        tcc_pkg::IDX_COMPARE_ONE_PIN_MASK:
          next_pinMask = hwdata[7:0] & tcc_pkg::PIN_MASK_BITS;
        tcc_pkg::IDX_COMPARE_ONE_PIN_DATA:
          next_pinData = hwdata[7:0] & tcc_pkg::PIN_MASK_BITS;
        tcc_pkg::IDX_COMPARE_VALUE_ONE:    next_cmpVal[0] = hwdata[15:0];
        tcc_pkg::IDX_COMPARE_VALUE_TWO:    next_cmpVal[1] = hwdata[15:0];
        tcc_pkg::IDX_COMPARE_VALUE_THREE:  next_cmpVal[2] = hwdata[15:0];
        tcc_pkg::IDX_COMPARE_VALUE_FOUR:   next_cmpVal[3] = hwdata[15:0];
        tcc_pkg::IDX_SHARED_VALUE:
          if (!sharedSel) next_sharedVal = hwdata[15:0];
        tcc_pkg::IDX_PIN_ACTION_CONTROL:   next_actCtl = hwdata[7:0];
        tcc_pkg::IDX_CAPTURE_EDGE_CONTROL: next_edgeCtl = hwdata[7:0];
        tcc_pkg::IDX_INTERRUPT_ENABLES:    next_ien = hwdata[7:0];
        tcc_pkg::IDX_EVENT_FLAGS: next_flags = flags & ~hwdata[7:0];
        tcc_pkg::IDX_COUNTER_CONTROL:
          next_cntCtl = {hwdata[7], 5'h00, hwdata[1:0]};
        tcc_pkg::IDX_COUNTER_FLAGS:
          if (hwdata[tcc_pkg::BIT_WRAP_FLAG]) next_wrapFlag = 1'b0;
        // select bit steers the shared pair
        tcc_pkg::IDX_PULSE_CONTROL:
          next_sharedSel = hwdata[tcc_pkg::BIT_SHARED_SELECT];
        default: next_flags = flags;
      endcase
    end
    // set wins over a same-cycle clear
    next_flags = next_flags | setFlags;
    if (tick && count == 16'hffff) begin
      next_wrapFlag = 1'b1;
    end
    if (capHit[3]) begin
      next_sharedVal = count;
    end

    next_portAOut  = portAOut;
    next_portAOe_n = 5'h1f;
    for (int i = 0; i < 4; i++) begin
      if (actCtl[7-2*i -: 2] != tcc_pkg::MODE_OFF && (i < 3 || !sharedSel))
      begin
        next_portAOe_n[6-i] = 1'b0;
      end
      if (cmpHit[i+1]) begin
        unique case (actCtl[7-2*i -: 2])
          tcc_pkg::MODE_OFF:    next_portAOut[6-i] = portAOut[6-i];
          tcc_pkg::MODE_TOGGLE: next_portAOut[6-i] = !portAOut[6-i];
          tcc_pkg::MODE_CLEAR:  next_portAOut[6-i] = 1'b0;
          default:              next_portAOut[6-i] = 1'b1;
        endcase
      end
    end
    // compare one overrides on masked pins
    for (int b = 3; b < 8; b++) begin
      if (pinMask[b]) begin
        next_portAOe_n[b] = 1'b0;
        if (cmpHit[0]) next_portAOut[b] = pinData[b];
      end
    end

    // shared enable sits on the shared flag
    next_timerIrq = |(next_flags & next_ien) ||
                    (next_wrapFlag && next_cntCtl[tcc_pkg::BIT_WRAP_ENABLE]);
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      dataPh    <= '0;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      pinSyncA  <= 4'h0;
      pinSync   <= 4'h0;
      pinPrev   <= 4'h0;
      count     <= tcc_pkg::RST_COUNT;
      preCnt    <= 4'h0;
      cntNew    <= 1'b0;
      for (int i = 0; i < 4; i++) cmpVal[i] <= tcc_pkg::RST_COMPARE;
      sharedVal <= tcc_pkg::RST_COMPARE;
      pinMask   <= tcc_pkg::RST_CONTROL;
      pinData   <= tcc_pkg::RST_CONTROL;
      actCtl    <= tcc_pkg::RST_CONTROL;
      edgeCtl   <= tcc_pkg::RST_CONTROL;
      ien       <= tcc_pkg::RST_CONTROL;
      flags     <= tcc_pkg::RST_CONTROL;
      cntCtl    <= tcc_pkg::RST_CONTROL;
      wrapFlag  <= 1'b0;
      sharedSel <= 1'b0;
      portAOut  <= 5'h00;
      portAOe_n <= 5'h1f;
      timerIrq  <= 1'b0;
    end else begin
      dataPh    <= next_dataPh;
      hrdata    <= next_hrdata;
      hreadyout <= next_hreadyout;
      hresp     <= 1'b0;
      pinSyncA  <= portAIn;
      pinSync   <= pinSyncA;
      pinPrev   <= pinSync;
      count     <= next_count;
      preCnt    <= next_preCnt;
      cntNew    <= tick;
      cmpVal    <= next_cmpVal;
      sharedVal <= next_sharedVal;
      pinMask   <= next_pinMask;
      pinData   <= next_pinData;
      actCtl    <= next_actCtl;
      edgeCtl   <= next_edgeCtl;
      ien       <= next_ien;
      flags     <= next_flags;
      cntCtl    <= next_cntCtl;
      wrapFlag  <= next_wrapFlag;
      sharedSel <= next_sharedSel;
      portAOut  <= next_portAOut;
      portAOe_n <= next_portAOe_n;
      timerIrq  <= next_timerIrq;
    end
  end

  // no reset term: captured values survive reset
  // latch counter on the selected edge
  always_ff @(posedge mclk) begin
    for (int i = 0; i < 3; i++) begin
      if (capHit[i]) capVal[i] <= count;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  AST_CNT_STEP: assert property (@(posedge mclk) disable iff (!rstN)
    tick |=> count == $past(count) + 16'h0001)
    else $error("counter did not step on tick");
  AST_CMP_FLAG: assert property (@(posedge mclk) disable iff (!rstN)
    cmpHit[0] |=> flags[7])
    else $error("compare one flag not set on match");
  AST_CMP_IRQ: assert property (@(posedge mclk) disable iff (!rstN)
    (flags[7] && ien[7]) |-> timerIrq)
    else $error("compare interrupt missing");
  AST_CAP_IRQ: assert property (@(posedge mclk) disable iff (!rstN)
    (flags[2] && ien[2]) |-> timerIrq)
    else $error("capture interrupt missing");
  AST_CAP_LATCH: assert property (@(posedge mclk) disable iff (!rstN)
    capHit[0] |=> (capVal[0] == $past(count)) && flags[2])
    else $error("capture one did not latch counter");
  AST_SHR_LOCK: assert property (@(posedge mclk) disable iff (!rstN)
    (wrEn && dataPh.idx == tcc_pkg::IDX_SHARED_VALUE && sharedSel
     && !capHit[3]) |=> $stable(sharedVal))
    else $error("shared pair written while capturing");
  AST_FLAG_KEEP: assert property (@(posedge mclk) disable iff (!rstN)
    (wrEn && dataPh.idx == tcc_pkg::IDX_EVENT_FLAGS)
    |=> (($past(flags) & ~$past(hwdata[7:0]) & ~flags) == 8'h00))
    else $error("flag written with zero was cleared");
  AST_WRAP: assert property (@(posedge mclk) disable iff (!rstN)
    (tick && count == 16'hffff) |=> wrapFlag && count == 16'h0000)
    else $error("wrap flag not set on wrap");
  AST_PIN_SET: assert property (@(posedge mclk) disable iff (!rstN)
    (cmpHit[1] && actCtl[7:6] == tcc_pkg::MODE_SET && !pinMask[6])
    |=> portAOut[6] && !portAOe_n[6])
    else $error("compare two did not set its pin");
  AST_EDGE_OFF: assert property (@(posedge mclk) disable iff (!rstN)
    (edgeCtl[5:4] == tcc_pkg::EDGE_OFF) |-> !capHit[0])
    else $error("capture one fired while disabled");
  COV_SHARED_CAPTURE: cover property (@(posedge mclk) disable iff (!rstN)
    capHit[3]);
  COV_SHARED_COMPARE: cover property (@(posedge mclk) disable iff (!rstN)
    cmpHit[4]);
  COV_SET_AND_CLEAR: cover property (@(posedge mclk) disable iff (!rstN)
    wrEn && dataPh.idx == tcc_pkg::IDX_EVENT_FLAGS && |setFlags);

endmodule : timer_capture_compare_unit
`default_nettype wire

// ### src/tcc_pkg.sv
// constants and carrier types for the timer capture and compare unit
package tcc_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_COMPARE_ONE_PIN_MASK  = 8'h0c;
  localparam logic [7:0] IDX_COMPARE_ONE_PIN_DATA  = 8'h0d;
  localparam logic [7:0] IDX_FREE_RUNNING_COUNT    = 8'h0e;
  localparam logic [7:0] IDX_CAPTURE_VALUE_ONE     = 8'h10;
  localparam logic [7:0] IDX_CAPTURE_VALUE_TWO     = 8'h12;
  localparam logic [7:0] IDX_CAPTURE_VALUE_THREE   = 8'h14;
  localparam logic [7:0] IDX_COMPARE_VALUE_ONE     = 8'h16;
  localparam logic [7:0] IDX_COMPARE_VALUE_TWO     = 8'h18;
  localparam logic [7:0] IDX_COMPARE_VALUE_THREE   = 8'h1a;
  localparam logic [7:0] IDX_COMPARE_VALUE_FOUR    = 8'h1c;
  localparam logic [7:0] IDX_SHARED_VALUE          = 8'h1e;
  localparam logic [7:0] IDX_PIN_ACTION_CONTROL    = 8'h20;
  localparam logic [7:0] IDX_CAPTURE_EDGE_CONTROL  = 8'h21;
  localparam logic [7:0] IDX_INTERRUPT_ENABLES     = 8'h22;
  localparam logic [7:0] IDX_EVENT_FLAGS           = 8'h23;
  localparam logic [7:0] IDX_COUNTER_CONTROL       = 8'h24;
  localparam logic [7:0] IDX_COUNTER_FLAGS         = 8'h25;
  localparam logic [7:0] IDX_PULSE_CONTROL         = 8'h26;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int BIT_SHARED_SELECT  = 2;  // in pulse control
  localparam int BIT_WRAP_FLAG      = 7;  // in counter flags
  localparam int BIT_WRAP_ENABLE    = 7;  // in counter control
  localparam int BIT_SHARED_FLAG    = 3;  // in event flags
  localparam logic [15:0] RST_COMPARE      = 16'hffff;
  localparam logic [15:0] RST_COUNT        = 16'h0000;
  localparam logic [7:0]  RST_CONTROL      = 8'h00;
  localparam logic [7:0]  PIN_MASK_BITS    = 8'hf8;
  localparam logic [1:0]  MODE_OFF         = 2'h0;
  localparam logic [1:0]  MODE_TOGGLE      = 2'h1;
  localparam logic [1:0]  MODE_CLEAR       = 2'h2;
  localparam logic [1:0]  MODE_SET         = 2'h3;
  localparam logic [1:0]  EDGE_OFF         = 2'h0;
  localparam logic [1:0]  EDGE_RISE        = 2'h1;
  localparam logic [1:0]  EDGE_FALL        = 2'h2;

  // ---------------------------------------------------------------
  // latched bus address phase
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] idx;
  } busPhase_t;

endpackage : tcc_pkg

// ### tb/port_a_pins.sv
// port a pin model: capture stimulus and pulled-up compare pins
`timescale 1ns/1ns
`default_nettype none
module port_a_pins (
  // bench side
  input  wire logic [3:0] capDrive,
  output var  logic [7:3] pinLevel,
  // unit side
  output var  logic [3:0] portAIn,
  input  wire logic [7:3] portAOut,
  input  wire logic [7:3] portAOe_n
);
  // edges follow the bench, which moves just after a clock edge
  assign portAIn = capDrive;
  // a released pin floats to its pull-up level
  always_comb begin
    for (int i = 3; i < 8; i++) begin
      pinLevel[i] = portAOe_n[i] ? 1'b1 : portAOut[i];
    end
  end
endmodule : port_a_pins
`default_nettype wire

// ### tb/timer_capture_compare_unit_tb_top.sv
// self-checking bench for the timer capture and compare unit
`timescale 1ns/1ns
`default_nettype none
module timer_capture_compare_unit_tb_top;
  localparam logic [7:0] CNT = tcc_pkg::IDX_FREE_RUNNING_COUNT;
  localparam logic [7:0] FLG = tcc_pkg::IDX_EVENT_FLAGS;
  localparam logic [7:0] ENA = tcc_pkg::IDX_INTERRUPT_ENABLES;
  localparam logic [7:0] SHR = tcc_pkg::IDX_SHARED_VALUE;
  logic        mclk, reset_n, hsel, hwrite, hreadyout, hresp, timerIrq;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, c0, c1;
  logic [3:0]  capDrive, portAIn, pinState;
  logic [7:3]  portAOut, portAOe_n, pinLevel;
  logic [15:0] lfsr, target, capVal, shared;
  int          failures, total_checks;
  logic [7:0]  onesIdx [5] = '{8'h16, 8'h18, 8'h1a, 8'h1c, 8'h1e};
  logic [7:0]  zeroIdx [10] = '{8'h0c, 8'h0d, 8'h20, 8'h21, 8'h22,
                                8'h23, 8'h24, 8'h25, 8'h26, 8'h30};

  timer_capture_compare_unit DUT (.mclk(mclk), .reset_n(reset_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .portAIn(portAIn), .portAOut(portAOut), .portAOe_n(portAOe_n),
    .timerIrq(timerIrq));
  port_a_pins pins (.capDrive(capDrive), .pinLevel(pinLevel),
    .portAIn(portAIn), .portAOut(portAOut), .portAOe_n(portAOe_n));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  function automatic logic [15:0] nextRand(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nextRand

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    if (failures == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  // the slave may stretch any phase, so wait on hready with a bound
  task automatic waitReady();
    int k;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    // judge by the signal, not the count: ready on the last try is fine
    if (hreadyout !== 1'b1) begin
      failures++;
      conclude();
    end
  endtask : waitReady

  task automatic xfer(input logic wr, input logic [7:0] idx,
                      input logic [31:0] wd);
    @(posedge mclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {22'h0, idx, 2'h0};
    waitReady();
    htrans <= 2'h0;
    hwdata <= wd;
    waitReady();
    rd = hrdata;
  endtask : xfer

  task automatic pollFor(input logic [7:0] idx, input logic [7:0] m,
                         input int lim);
    int k;
    k = 0;
    do begin
      xfer(1'b0, idx, 32'h0);
      k++;
    end while ((rd[7:0] & m) !== m && k < lim);
    if ((rd[7:0] & m) !== m) begin
      failures++;
      conclude();
    end
  endtask : pollFor

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    capDrive = 4'h0;
    failures = 0;
    total_checks = 0;
    lfsr = 16'h0006;
    pinState = 4'h0;
    cyc(2);
    reset_n <= 1'b1;
    cyc(3);
    xfer(1'b1, 8'h30, 32'h5a5a);
    foreach (onesIdx[i]) begin
      xfer(1'b0, onesIdx[i], 32'h0);
      check(rd, 32'h0000ffff);
    end
    foreach (zeroIdx[i]) begin
      xfer(1'b0, zeroIdx[i], 32'h0);
      check(rd, 32'h0);
    end
    xfer(1'b0, CNT, 32'h0);
    c0 = rd;
    lfsr = nextRand(lfsr);
    xfer(1'b1, CNT, {16'h0, lfsr});
    xfer(1'b0, CNT, 32'h0);
    check(32'(rd > c0 && rd - c0 < 32'd20), 32'h1);
    // every action code on compare channels two to five at once
    for (int m = 0; m < 4; m++) begin
      xfer(1'b1, FLG, 32'hff);
      xfer(1'b1, tcc_pkg::IDX_PIN_ACTION_CONTROL, 32'({4{2'(m)}}));
      xfer(1'b0, CNT, 32'h0);
      lfsr = nextRand(lfsr);
      target = rd[15:0] + 16'd60 + {11'h0, lfsr[4:0]};
      for (int c = 0; c < 4; c++) begin
        xfer(1'b1, tcc_pkg::IDX_COMPARE_VALUE_TWO + 8'(2 * c), 32'(target));
      end
      xfer(1'b0, SHR, 32'h0);
      check(rd, 32'(target));
      pollFor(FLG, 8'h78, 40);
      check(rd, 32'h78);
      if (m == 1) pinState = ~pinState;
      else if (m > 1) pinState = {4{m[0]}};
      check(32'({portAOe_n, pinLevel}), 32'({1'b1, {4{m == 0}}, 1'b1,
            (m == 0) ? 4'hf : pinState}));
      check(32'(timerIrq), 32'h0);
    end
    shared = target;
    xfer(1'b1, ENA, 32'h40);
    cyc(2);
    check(32'(timerIrq), 32'h1);
    xfer(1'b1, ENA, 32'h08);
    cyc(2);
    check(32'(timerIrq), 32'h1);
    xfer(1'b1, ENA, 32'h04);
    cyc(2);
    check(32'(timerIrq), 32'h0);
    xfer(1'b1, FLG, 32'h40);
    xfer(1'b0, FLG, 32'h0);
    check(rd, 32'h38);
    xfer(1'b1, ENA, 32'h40);
    cyc(2);
    check(32'(timerIrq), 32'h0);
    // compare one drives masked pins with its data bits
    xfer(1'b1, tcc_pkg::IDX_COMPARE_ONE_PIN_MASK, 32'hc0);
    xfer(1'b1, tcc_pkg::IDX_COMPARE_ONE_PIN_DATA, 32'h80);
    xfer(1'b1, FLG, 32'hff);
    xfer(1'b0, CNT, 32'h0);
    target = rd[15:0] + 16'd40;
    xfer(1'b1, tcc_pkg::IDX_COMPARE_VALUE_ONE, 32'(target));
    pollFor(FLG, 8'h80, 40);
    check(rd, 32'h80);
    check(32'({portAOe_n, pinLevel}), 32'h017);
    // shared channel as capture four
    xfer(1'b1, tcc_pkg::IDX_PULSE_CONTROL, 32'h04);
    lfsr = nextRand(lfsr);
    xfer(1'b1, SHR, {16'h0, lfsr});
    check(32'(hresp), 32'h0);
    xfer(1'b0, SHR, 32'h0);
    check(rd, 32'(shared));
    for (int e = 0; e < 4; e++) begin
      xfer(1'b1, tcc_pkg::IDX_CAPTURE_EDGE_CONTROL, 32'({4{2'(e)}}));
      for (int lv = 1; lv >= 0; lv--) begin
        xfer(1'b1, FLG, 32'hff);
        xfer(1'b0, CNT, 32'h0);
        c0 = rd;
        capDrive <= {4{lv[0]}};
        cyc(8);
        xfer(1'b0, FLG, 32'h0);
        check(rd, ((lv == 1) ? e[0] : e[1]) ? 32'h0f : 32'h0);
        if (e == 1 && lv == 1) begin
          xfer(1'b0, CNT, 32'h0);
          c1 = rd;
          xfer(1'b0, tcc_pkg::IDX_CAPTURE_VALUE_ONE, 32'h0);
          check(32'(rd >= c0 && rd <= c1), 32'h1);
          xfer(1'b0, SHR, 32'h0);
          check(32'(rd >= c0 && rd <= c1), 32'h1);
        end
      end
    end
    xfer(1'b0, tcc_pkg::IDX_CAPTURE_VALUE_ONE, 32'h0);
    capVal = rd[15:0];
    xfer(1'b1, ENA, 32'h08);
    cyc(2);
    check(32'(timerIrq), 32'h1);
    xfer(1'b1, ENA, 32'h04);
    cyc(2);
    check(32'(timerIrq), 32'h1);
    // wait for the counter to wrap
    pollFor(tcc_pkg::IDX_COUNTER_FLAGS, 8'h80, 20000);
    check(32'(rd[7]), 32'h1);
    // second reset in mid-run
    reset_n <= 1'b0;
    cyc(2);
    reset_n <= 1'b1;
    cyc(3);
    xfer(1'b0, tcc_pkg::IDX_CAPTURE_VALUE_ONE, 32'h0);
    check(rd, 32'(capVal));
    xfer(1'b0, tcc_pkg::IDX_COMPARE_VALUE_TWO, 32'h0);
    check(rd, 32'h0000ffff);
    xfer(1'b0, CNT, 32'h0);
    check(32'(rd < 32'd16), 32'h1);
    // divide by four and wrap enable: count must slow to a quarter
    xfer(1'b1, tcc_pkg::IDX_COUNTER_CONTROL, 32'h81);
    xfer(1'b0, tcc_pkg::IDX_COUNTER_CONTROL, 32'h0);
    check(rd, 32'h81);
    xfer(1'b0, CNT, 32'h0);
    c0 = rd;
    cyc(40);
    xfer(1'b0, CNT, 32'h0);
    check(32'(rd - c0 >= 32'd9 && rd - c0 <= 32'd12), 32'h1);
    check(32'(timerIrq), 32'h0);
    conclude();
  end
endmodule : timer_capture_compare_unit_tb_top
`default_nettype wire
